// ### verilog/ext_mem_defines.vh
`ifndef EXT_MEM_DEFINES_VH
`define EXT_MEM_DEFINES_VH

// Register offsets on the plain register port.
`define TIMING_CTRL_ADDR 8'hAF
`define CONFIG_ADDR 8'hAE
`define BANK_ADDR 8'hAA
`define STATUS_ADDR 8'hAD

// Timing control field layout.
`define SETUP_MSB 7
`define SETUP_LSB 6
`define WIDTH_MSB 5
`define WIDTH_LSB 2
`define HOLD_MSB 1
`define HOLD_LSB 0
`define TIMING_RESET 8'hFF

// Configuration register: [4:2] interface mode, [1:0] latch pulse width.
`define MODE_MSB 4
`define MODE_LSB 2
`define ALE_MSB 1
`define ALE_LSB 0
`define CONFIG_RESET 8'h1F
`define BANK_RESET 8'h00

// Fixed overhead of an access in system clock cycles.
`define OVERHEAD_CYCLES 5'h04
`define OVERHEAD_PRE 5'h02
`define OVERHEAD_POST 5'h02

`endif

// ### verilog/phase_counter.v
`timescale 1ns/100ps
// Loadable down counter; done is high when the count is zero.
module phase_counter (
    input wire CLK,
    input wire RST_B,
    input wire load,
    input wire [4:0] value,
    output wire done
);
    reg [4:0] cnt_q;
    reg [4:0] cnt_d;

    always @* begin
        cnt_d = cnt_q;
        if (load) begin
            cnt_d = value;
        end else if (cnt_q != 5'h00) begin
            cnt_d = cnt_q - 5'h01;
        end
    end

    always @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            cnt_q <= 5'h00;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    assign done = (cnt_q == 5'h00);
endmodule

// ### verilog/ext_mem_timing.v
`timescale 1ns/100ps
`include "ext_mem_defines.vh"
module ext_mem_timing (
    input wire CLK,
    input wire RST_B,
    input wire [7:0] REG_ADDR,
    input wire [7:0] REG_WDATA,
    input wire REG_WR,
    input wire REG_RD,
    output reg [7:0] REG_RDATA,
    input wire REQ,
    input wire REQ_WRITE,
    input wire REQ_WIDE,
    input wire [15:0] REQ_ADDR,
    input wire [7:0] REQ_WDATA,
    output wire REQ_BUSY,
    output reg DONE,
    output reg [7:0] RDATA,
    output reg [7:0] ADDR_HI_OUT,
    output reg ADDR_HI_OE,
    output reg [7:0] ADDR_LO_OUT,
    output reg ADDR_LO_OE,
    output reg [7:0] DATA_OUT,
    output reg DATA_OE,
    input wire [7:0] DATA_IN,
    output reg ALE,
    output reg RD_B,
    output reg WR_B
);
    localparam IDLE = 3'h0;
    localparam PRE = 3'h1;
    localparam LAT_H = 3'h2;
    localparam LAT_L = 3'h3;
    localparam SETUP = 3'h4;
    localparam STROBE = 3'h5;
    localparam HOLD = 3'h6;
    localparam POST = 3'h7;

    reg [7:0] ext_mem_timing_control_q;
    reg [7:0] ext_mem_config_q;
    reg [7:0] ext_mem_bank_register_q;
    reg [2:0] state_q;
    reg [2:0] state_d;
    reg load;
    reg [4:0] load_val;
    reg write_q;
    reg muxed_q;
    reg drive_hi_q;
    reg [15:0] addr_q;
    reg [7:0] wdata_q;
    reg [7:0] din_s1_q;
    reg [7:0] din_s2_q;
    reg rd_end_q;
    reg rd_end2_q;
    wire done_cnt;
    wire [1:0] setup_f;
    wire [3:0] width_f;
    wire [1:0] hold_f;
    wire [2:0] mode_f;
    wire [1:0] ale_f;
    wire mode_nonmux;
    wire bank_used;

    assign setup_f = ext_mem_timing_control_q[`SETUP_MSB:`SETUP_LSB];
    assign width_f = ext_mem_timing_control_q[`WIDTH_MSB:`WIDTH_LSB];
    assign hold_f = ext_mem_timing_control_q[`HOLD_MSB:`HOLD_LSB];
    assign mode_f = ext_mem_config_q[`MODE_MSB:`MODE_LSB];
    assign ale_f = ext_mem_config_q[`ALE_MSB:`ALE_LSB];
    assign mode_nonmux = (mode_f == 3'h5) || (mode_f == 3'h6) ||
        (mode_f == 3'h7);
    // Mode 110 is bank select on separate pins and mode 010 its multiplexed
    // form; every other mode leaves the upper byte to the port latches unless the request is wide.
    // bank use
    assign bank_used = (mode_f == 3'h6) || (mode_f == 3'h2);
    // A request while busy is dropped, so callers must wait for idle.
    assign REQ_BUSY = (state_q != IDLE);

    phase_counter counter (
        .CLK(CLK),
        .RST_B(RST_B),
        .load(load),
        .value(load_val),
        .done(done_cnt)
    );

    always @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            ext_mem_timing_control_q <= `TIMING_RESET;
            ext_mem_config_q <= `CONFIG_RESET;
            ext_mem_bank_register_q <= `BANK_RESET;
            REG_RDATA <= 8'h00;
        end else begin
            REG_RDATA <= 8'h00;
            if (REG_WR) begin
                case (REG_ADDR)
                    `TIMING_CTRL_ADDR: ext_mem_timing_control_q <= REG_WDATA;
                    // Unused configuration bits stay zero and read as zero.
                    `CONFIG_ADDR: ext_mem_config_q <= {3'h0, REG_WDATA[4:0]};
                    `BANK_ADDR: ext_mem_bank_register_q <= REG_WDATA;
                    default: ;
                endcase
            end
            if (REG_RD) begin
                case (REG_ADDR)
                    `TIMING_CTRL_ADDR: REG_RDATA <= ext_mem_timing_control_q;
                    `CONFIG_ADDR: REG_RDATA <= ext_mem_config_q;
                    `BANK_ADDR: REG_RDATA <= ext_mem_bank_register_q;
                    `STATUS_ADDR: REG_RDATA <= {5'h00, state_q};
                    default: REG_RDATA <= 8'h00;
                endcase
            end
        end
    end

    // Each phase loads its length minus one; the counter ends the phase.
    always @* begin
        state_d = state_q;
        load = 1'b0;
        load_val = 5'h00;
        case (state_q)
            IDLE: begin
                if (REQ) begin
                    state_d = PRE;
                    load = 1'b1;
                    load_val = `OVERHEAD_PRE - 5'h01;
                end
            end
            PRE: begin
                if (done_cnt) begin
                    load = 1'b1;
                    if (muxed_q) begin
                        state_d = LAT_H;
                        load_val = {3'h0, ale_f};
                    end else if (setup_f != 2'h0) begin
                        state_d = SETUP;
                        load_val = {3'h0, setup_f} - 5'h01;
                    end else begin
                        state_d = STROBE;
                        load_val = {1'b0, width_f};
                    end
                end
            end
            LAT_H: begin
                if (done_cnt) begin
                    state_d = LAT_L;
                    load = 1'b1;
                    load_val = {3'h0, ale_f};
                end
            end
            LAT_L: begin
                if (done_cnt) begin
                    load = 1'b1;
                    if (setup_f != 2'h0) begin
                        state_d = SETUP;
                        load_val = {3'h0, setup_f} - 5'h01;
                    end else begin
                        state_d = STROBE;
                        load_val = {1'b0, width_f};
                    end
                end
            end
            SETUP: begin
                if (done_cnt) begin
                    state_d = STROBE;
                    load = 1'b1;
                    load_val = {1'b0, width_f};
                end
            end
            STROBE: begin
                if (done_cnt) begin
                    load = 1'b1;
                    if (hold_f != 2'h0) begin
                        state_d = HOLD;
                        load_val = {3'h0, hold_f} - 5'h01;
                    end else begin
                        state_d = POST;
                        load_val = `OVERHEAD_POST - 5'h01;
                    end
                end
            end
            HOLD: begin
                if (done_cnt) begin
                    state_d = POST;
                    load = 1'b1;
                    load_val = `OVERHEAD_POST - 5'h01;
                end
            end
            POST: begin
                if (done_cnt) begin
                    state_d = IDLE;
                end
            end
            default: state_d = IDLE;
        endcase
    end

    always @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            state_q <= IDLE;
            write_q <= 1'b0;
            muxed_q <= 1'b0;
            drive_hi_q <= 1'b0;
            addr_q <= 16'h0000;
            wdata_q <= 8'h00;
            din_s1_q <= 8'h00;
            din_s2_q <= 8'h00;
            rd_end_q <= 1'b0;
            rd_end2_q <= 1'b0;
            DONE <= 1'b0;
            RDATA <= 8'h00;
        end else begin
            state_q <= state_d;
            din_s1_q <= DATA_IN;
            din_s2_q <= din_s1_q;
            DONE <= (state_q == POST) && done_cnt;
            if (state_q == IDLE && REQ) begin
                write_q <= REQ_WRITE;
                muxed_q <= !mode_nonmux;
                wdata_q <= REQ_WDATA;
                addr_q <= REQ_WIDE ? REQ_ADDR :
                    {ext_mem_bank_register_q, REQ_ADDR[7:0]};
                drive_hi_q <= REQ_WIDE || bank_used;
            end
            // The data pins pass two synchroniser stages, so the value seen
            // in the last strobe cycle reaches the second stage two clocks
            // later; the memory need only hold it until the strobe rises.
            // read capture
            rd_end_q <= (state_q == STROBE) && done_cnt && !write_q;
            rd_end2_q <= rd_end_q;
            if (rd_end2_q) begin
                RDATA <= din_s2_q;
            end
        end
    end

    // Pin outputs are registered from the next state to avoid glitches.
    // Address enables drop in the overhead phases, so the pins are only
    // driven while the access itself runs.
    always @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            ADDR_HI_OUT <= 8'h00;
            ADDR_HI_OE <= 1'b0;
            ADDR_LO_OUT <= 8'h00;
            ADDR_LO_OE <= 1'b0;
            DATA_OUT <= 8'h00;
            DATA_OE <= 1'b0;
            ALE <= 1'b0;
            RD_B <= 1'b1;
            WR_B <= 1'b1;
        end else begin
            ADDR_HI_OUT <= addr_q[15:8];
            ADDR_HI_OE <= drive_hi_q && (state_d != IDLE) &&
                (state_d != PRE) && (state_d != POST);
            ADDR_LO_OUT <= addr_q[7:0];
            ADDR_LO_OE <= !muxed_q && (state_d != IDLE) &&
                (state_d != PRE) && (state_d != POST);
            if (muxed_q && state_d == LAT_H) begin
                DATA_OUT <= addr_q[7:0];
                DATA_OE <= 1'b1;
            end else begin
                DATA_OUT <= wdata_q;
                DATA_OE <= write_q && ((state_d == SETUP) ||
                    (state_d == STROBE) || (state_d == HOLD) ||
                    (state_d == LAT_L));
            end
            ALE <= (state_d == LAT_H);
            RD_B <= !(!write_q && state_d == STROBE);
            WR_B <= !(write_q && state_d == STROBE);
        end
    end
endmodule

// ### test/ext_mem_timing_props.sv
`timescale 1ns/100ps
module ext_mem_timing_props (
    input wire CLK,
    input wire RST_B,
    input wire REQ,
    input wire REQ_BUSY,
    input wire DONE,
    input wire DATA_OE,
    input wire ALE,
    input wire RD_B,
    input wire WR_B
);
    default clocking @(posedge CLK); endclocking
    default disable iff (!RST_B);
    chk_two_strobes:
        assert property (RD_B || WR_B) else $error("both strobes low");
    chk_min_len:
        assert property ($rose(REQ_BUSY) |-> REQ_BUSY [*5])
        else $error("access under five cycles");
    // The longest access is 4 + 3 + 16 + 3 + 2 * 4 clocks.
    chk_max_len:
        assert property ($rose(REQ_BUSY) |-> ##[5:34] !REQ_BUSY)
        else $error("access too long");
    chk_req_taken:
        assert property (REQ && !REQ_BUSY |=> REQ_BUSY)
        else $error("request not taken");
    chk_done_end:
        assert property ($fell(REQ_BUSY) |-> DONE)
        else $error("no done at access end");
    chk_done_pulse:
        assert property (DONE |=> !DONE) else $error("done too long");
    chk_idle_pins:
        assert property (!REQ_BUSY |-> RD_B && WR_B && !ALE)
        else $error("pins active while idle");
    chk_ale_addr:
        assert property (ALE |-> DATA_OE && RD_B && WR_B)
        else $error("shared pins wrong under latch");
    chk_rd_release:
        assert property (!RD_B |-> !DATA_OE)
        else $error("data driven during read");
endmodule
bind ext_mem_timing ext_mem_timing_props ext_mem_timing_props_inst (
    .CLK, .RST_B, .REQ, .REQ_BUSY, .DONE, .DATA_OE, .ALE, .RD_B, .WR_B);

// ### test/ext_mem_model.sv
`timescale 1ns/100ps
module ext_mem_model (
    input wire CLK,
    input wire RD_B,
    input wire WR_B,
    input wire ALE,
    input wire MUXED,
    input wire [7:0] ADDR_LO,
    input wire [7:0] AD,
    output wire [7:0] DATA_IN
);
    reg [7:0] mem [0:255];
    reg [7:0] lat = 8'h00;
    reg [7:0] last = 8'h00;
    wire [7:0] a = MUXED ? lat : ADDR_LO;
    // read data held
    // Data stands only while the read strobe is low; a released bus
    // toggles so that a late sample cannot match by luck.
    assign DATA_IN = !RD_B ? mem[a] : ~last;
    always @(posedge CLK) begin
        last <= DATA_IN;
        if (ALE)
            lat <= AD;
        if (!WR_B)
            mem[a] <= AD;
    end
endmodule

// ### test/ext_mem_timing_tb.sv
`timescale 1ns/100ps
module ext_mem_timing_tb;
    logic CLK, RST_B, REG_WR, REG_RD, REQ, REQ_WRITE, REQ_WIDE, mx, hi_oe;
    logic lo_oe;
    logic [7:0] REG_ADDR, REG_WDATA, REQ_WDATA, REG_RDATA, RDATA, hi, lo;
    logic [15:0] REQ_ADDR;
    logic REQ_BUSY, DONE, ADDR_HI_OE, ADDR_LO_OE, DATA_OE, ALE, RD_B, WR_B;
    logic [7:0] ADDR_HI_OUT, ADDR_LO_OUT, DATA_OUT, DATA_IN;
    int n_fail = 0, n_checks = 0, i;
    ext_mem_timing ext_mem_timing_inst (.CLK(CLK), .RST_B(RST_B),
        .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR),
        .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .REQ(REQ),
        .REQ_WRITE(REQ_WRITE), .REQ_WIDE(REQ_WIDE), .REQ_ADDR(REQ_ADDR),
        .REQ_WDATA(REQ_WDATA), .REQ_BUSY(REQ_BUSY), .DONE(DONE),
        .RDATA(RDATA), .ADDR_HI_OUT(ADDR_HI_OUT), .ADDR_HI_OE(ADDR_HI_OE),
        .ADDR_LO_OUT(ADDR_LO_OUT), .ADDR_LO_OE(ADDR_LO_OE),
        .DATA_OUT(DATA_OUT), .DATA_OE(DATA_OE), .DATA_IN(DATA_IN),
        .ALE(ALE), .RD_B(RD_B), .WR_B(WR_B));
    ext_mem_model ext_mem_model_inst (.CLK(CLK), .RD_B(RD_B), .WR_B(WR_B),
        .ALE(ALE), .MUXED(mx), .ADDR_LO(ADDR_LO_OUT), .AD(DATA_OUT),
        .DATA_IN(DATA_IN));
    initial begin
        CLK = 1'b0;
        forever #2.5 CLK = ~CLK;
    end
    task check(input string s, input logic [15:0] e, input logic [15:0] g);
        n_checks++;
        if (g !== e) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", s, e, g);
        end
    endtask
    task reg_wr(input logic [7:0] a, input logic [7:0] d);
        REG_WR <= 1'b1;
        REG_ADDR <= a;
        REG_WDATA <= d;
        @(posedge CLK);
        REG_WR <= 1'b0;
        @(posedge CLK);
    endtask
    task reg_rd(input logic [7:0] a, input logic [7:0] e);
        REG_RD <= 1'b1;
        REG_ADDR <= a;
        @(posedge CLK);
        REG_RD <= 1'b0;
        #1 check("register", e, REG_RDATA);
        @(posedge CLK);
    endtask
    // Counts busy cycles and records the pins seen during the strobe.
    task acc(input logic w, input logic wd, input logic [15:0] a,
             input logic [7:0] d, input int n);
        int c;
        c = 0;
        REQ <= 1'b1;
        REQ_WRITE <= w;
        REQ_WIDE <= wd;
        REQ_ADDR <= a;
        REQ_WDATA <= d;
        @(posedge CLK);
        REQ <= 1'b0;
        #1 while (REQ_BUSY === 1'b1 && c < 100) begin
            if (RD_B === 1'b0 || WR_B === 1'b0) begin
                hi_oe = ADDR_HI_OE;
                lo_oe = ADDR_LO_OE;
                hi = ADDR_HI_OUT;
                lo = ADDR_LO_OUT;
            end
            c++;
            @(posedge CLK);
            #1;
        end
        check("busy cycles", 16'(n), 16'(c));
        check("done", 16'h0001, {15'h0000, DONE});
        @(posedge CLK);
    endtask
    task end_sim;
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        #20000;
        n_fail++;
        end_sim();
    end
    initial begin
        {RST_B, REG_WR, REG_RD, REQ, REQ_WRITE, REQ_WIDE, mx} = '0;
        {REG_ADDR, REG_WDATA, REQ_WDATA, REQ_ADDR} = '0;
        repeat (2) @(posedge CLK);
        RST_B <= 1'b1;
        @(posedge CLK);
        reg_rd(8'hAF, 8'hFF);
        reg_rd(8'hAE, 8'h1F);
        reg_rd(8'hAA, 8'h00);
        reg_rd(8'h00, 8'h00);
        reg_rd(8'hAD, 8'h00);
        acc(1'b1, 1'b1, 16'h1234, 8'h5A, 26);
        acc(1'b0, 1'b1, 16'h1234, 8'h00, 26);
        check("read data", 16'h005A, {8'h00, RDATA});
        check("wide high", 16'h0112, {7'h00, hi_oe, hi});
        check("low oe", 16'h0001, {15'h0000, lo_oe});
        for (i = 0; i < 4; i++) begin
            reg_wr(8'hAF, {i[1:0], 4'(i * 5), i[1:0]});
            acc(1'b0, 1'b1, 16'h1234, 8'h00, 5 + 2 * i + i * 5);
        end
        reg_wr(8'hAF, 8'h00);
        reg_wr(8'hAA, 8'hC3);
        reg_wr(8'hAE, 8'h18);
        acc(1'b0, 1'b0, 16'h0034, 8'h00, 5);
        check("bank high", 16'h01C3, {7'h00, hi_oe, hi});
        check("low byte", 16'h0034, {8'h00, lo});
        for (i = 0; i < 2; i++) begin
            reg_wr(8'hAE, i ? 8'h1C : 8'h14);
            acc(1'b0, 1'b0, 16'h0034, 8'h00, 5);
            check("no bank", 16'h0000, {15'h0000, hi_oe});
        end
        mx <= 1'b1;
        for (i = 0; i < 4; i++) begin
            reg_wr(8'hAE, 8'h04 | 8'(i));
            acc(1'b1, 1'b0, 16'h0077, 8'hA5 ^ 8'(i), 7 + 2 * i);
            acc(1'b0, 1'b0, 16'h0077, 8'h00, 7 + 2 * i);
            check("mux data", {8'h00, 8'hA5 ^ 8'(i)}, {8'h00, RDATA});
            check("mux low oe", 16'h0000, {15'h0000, lo_oe});
        end
        end_sim();
    end
endmodule
